// File: logic/spdc_pkg.sv
// constants, field layouts and state types of the stepper pulse controller
`default_nettype none
package spdc_pkg;
   localparam int          NCH         = 3;
   localparam int          CLK_HZ      = 50_000_000;  // clk_sys rate
   localparam int          STEP_HI_NS  = 5000;        // step pulse high time
   localparam int          STEP_HI_CYC = (STEP_HI_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [13:0] PPS_MIN     = 14'h0001;
   localparam logic [13:0] PPS_MAX     = 14'h2710;    // 10000 pulses per second
   localparam int          RAMP_SH     = 3;           // ramp floor is rate / 8
   // command opcodes
   localparam logic [2:0]  OP_REL      = 3'h1;        // relative_move_cmd
   localparam logic [2:0]  OP_ABS      = 3'h2;        // absolute_move_cmd
   localparam logic [2:0]  OP_CFG      = 3'h3;        // profile_config_cmd
   localparam logic [2:0]  OP_STOP     = 3'h4;        // abort_motion_cmd
   localparam logic [2:0]  OP_HOME     = 3'h5;        // set_origin_cmd
   // command word fields
   localparam int          CMD_CH_LSB  = 0;
   localparam int          CMD_OP_LSB  = 2;
   // profile word fields
   localparam int          CFG_PPS_LSB = 0;
   localparam int          CFG_HALF    = 14;
   localparam int          CFG_ACC_LSB = 16;
   // register byte offsets
   localparam logic [7:0]  REG_ARG     = 8'h00;
   localparam logic [7:0]  REG_CFG     = 8'h04;
   localparam logic [7:0]  REG_CMD     = 8'h08;
   localparam logic [7:0]  REG_STAT    = 8'h0C;
   localparam logic [7:0]  REG_MASK    = 8'h10;
   localparam logic [7:0]  REG_POS0    = 8'h14;       // read_abs_position, one word per channel
   localparam logic [7:0]  REG_REM0    = 8'h20;       // read_rel_count, one word per channel
   localparam logic [7:0]  REG_PROF0   = 8'h2C;       // stored profile, one word per channel

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } spdc_bus_type;

   typedef struct packed {
      logic [13:0]        pps;     // configured top rate
      logic [15:0]        accs;    // ramp length in steps
      logic               half;    // half-step driver mode
      logic               cfg_ok;  // profile loaded since power-up
      logic               busy;
      logic               dir;     // high while moving negative
      logic [31:0]        rem;     // pulses still to emit
      logic signed [31:0] pos;
      logic [13:0]        cur;     // present rate
      logic [15:0]        k;       // position on the ramp
      logic signed [19:0] err;     // ramp remainder
      logic [25:0]        ph;      // rate phase accumulator
      logic [7:0]         pw;      // pulse high counter
      logic               step;
   } spdc_chan_type;

   typedef struct packed {
      spdc_chan_type [NCH-1:0] ch;
      logic [NCH-1:0]          stat;
      logic [NCH-1:0]          mask;
      logic                    irq;
      logic [31:0]             arg;
      logic [31:0]             cfgw;
      logic [31:0]             rdata;
   } spdc_state_type;
endpackage : spdc_pkg
`default_nettype wire

// File: logic/spdc_top.sv
// three-channel stepper pulse and direction controller with trapezoidal ramps
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - channel 1 to 3 selects controller channel
// RQ2 - software loads profile before first move
// RQ3 - profile kept across soft reset
// RQ4 - rate 1 to 10000, never exceeded
// RQ5 - ramp length in steps, up and down
// RQ6 - moves run trajectory from stored profile
// RQ7 - relative move emits exact signed count
// RQ8 - half-step mode counts half steps
// RQ9 - relative move clears flag, sets when done
// RQ10 - absolute move clears flag, sets at target
// RQ11 - target is signed 32-bit from home
// RQ12 - count and direction from target minus position
// RQ13 - home command zeroes position reference
// RQ14 - position readable at any time
// RQ15 - moves ignored while channel busy
// RQ16 - direction high for negative motion
// RQ17 - ramp from and to one eighth rate
// RQ18 - position follows every pulse, even aborted
module spdc_top
   import spdc_pkg::*;
(
   input  wire logic           clk_sys,   // system clock
   input  wire logic           sys_rst,   // power-up reset, async, high
   input  wire logic           soft_rst,  // software reset pulse
   input  wire spdc_bus_type   bus_i,     // register port
   output logic [31:0]         rdata_o,   // read data, cycle after rd
   output logic [NCH-1:0]      step_o,    // step pulses to drivers
   output logic [NCH-1:0]      dir_o,     // direction levels
   output logic [NCH-1:0]      half_o,    // half-step mode per channel
   output logic                irq_o      // level interrupt
);

   spdc_state_type q, d;

   // ramp floor, never below one pulse per second
   function automatic logic [13:0] floor_rate(input logic [13:0] pps);
      logic [13:0] f;
      f = pps >> RAMP_SH;
      return (f == 14'h0000) ? 14'h0001 : f;
   endfunction : floor_rate

   // command addressed to one channel; code 0 names no channel
   function automatic logic cmd_hit(input spdc_bus_type b, input int i);
      return b.wr && b.addr == REG_CMD && 32'(b.wdata[CMD_CH_LSB +: 2]) == i + 1;
   endfunction : cmd_hit

   // next state of the whole block
   always_comb
   begin
      spdc_chan_type      c;
      logic [2:0]         op;
      logic [31:0]        mag;
      logic [31:0]        delta;
      logic [13:0]        diff;
      logic [NCH-1:0]     hw_set;
      logic [NCH-1:0]     hw_clr;
      c      = '0;
      op     = bus_i.wdata[CMD_OP_LSB +: 3];
      mag    = '0;
      delta  = '0;
      diff   = '0;
      hw_set = '0;
      hw_clr = '0;
      d      = q;
      d.rdata = '0;
      for (int i = 0; i < NCH; i++)
      begin
         c    = q.ch[i];
         diff = c.pps - floor_rate(c.pps);
         // pulse high time, independent of the rate
         if (c.pw != 8'h00)
            c.pw = c.pw - 8'h01;
         c.step = (c.pw != 8'h00);
         // walk the rate one unit a cycle toward the ramp value
         if (c.busy && c.err >= $signed({4'h0, c.accs}) && c.accs != 16'h0000)
         begin
            c.err = c.err - $signed({4'h0, c.accs});
            c.cur = c.cur + 14'h0001;  // see RQ5
         end
         else if (c.busy && c.err < 0)
         begin
            c.err = c.err + $signed({4'h0, c.accs});
            c.cur = c.cur - 14'h0001;  // see RQ5
         end
         // phase accumulator turns the rate into pulse instants
         if (c.busy)
         begin
            c.ph = c.ph + {12'h000, c.cur};
            if (c.ph >= 26'(CLK_HZ))
            begin
               c.ph   = c.ph - 26'(CLK_HZ);
               c.pw   = 8'(STEP_HI_CYC);
               c.step = 1'b1;
               c.rem  = c.rem - 32'h0000_0001;             // see RQ7
               c.pos  = c.dir ? c.pos - 1 : c.pos + 1;     // see RQ18
               // slow down once the remaining steps reach the ramp position
               if (c.rem <= {16'h0000, c.k} && c.k != 16'h0000)
               begin
                  c.k   = c.k - 16'h0001;
                  c.err = c.err - $signed({6'h00, diff});  // see RQ17
               end
               else if (c.k < c.accs)
               begin
                  c.k   = c.k + 16'h0001;
                  c.err = c.err + $signed({6'h00, diff});  // see RQ5
               end
               if (c.rem == 32'h0000_0000)
               begin
                  c.busy    = 1'b0;
                  hw_set[i] = 1'b1;                        // see RQ9
               end
            end
         end
         // commands for this channel
         if (cmd_hit(bus_i, i))                            // see RQ1
         begin
            case (op)
               OP_REL, OP_ABS:
               begin
                  // a running move locks out new moves; profile must exist
                  if (!q.ch[i].busy && c.cfg_ok)           // see RQ15
                  begin
                     delta = q.arg - ((op == OP_ABS) ? q.ch[i].pos : 32'h0000_0000);  // see RQ12
                     mag   = delta[31] ? 32'h0000_0000 - delta : delta;               // see RQ11
                     // count is in the driver's unit, half steps in half mode
                     c.dir  = delta[31];                   // see RQ16
                     c.rem  = mag;                         // see RQ8
                     c.k    = 16'h0000;
                     c.err  = '0;
                     c.ph   = '0;
                     c.cur  = (c.accs == 16'h0000) ? c.pps : floor_rate(c.pps);  // see RQ6
                     c.busy = (mag != 32'h0000_0000);
                     hw_clr[i] = 1'b1;                     // see RQ10
                     hw_set[i] = (mag == 32'h0000_0000);
                  end
               end
               OP_CFG:
               begin
                  // rate is clamped so the output can never run faster
                  c.pps = q.cfgw[CFG_PPS_LSB +: 14];       // see RQ4
                  if (c.pps < PPS_MIN)
                     c.pps = PPS_MIN;
                  else if (c.pps > PPS_MAX)
                     c.pps = PPS_MAX;
                  c.accs   = q.cfgw[CFG_ACC_LSB +: 16];    // see RQ5
                  c.half   = q.cfgw[CFG_HALF];             // see RQ8
                  c.cfg_ok = 1'b1;                         // see RQ2
               end
               OP_STOP:
               begin
                  c.busy = 1'b0;
                  c.rem  = 32'h0000_0000;
               end
               OP_HOME:
                  c.pos = '0;                              // see RQ13
               default:
                  c.busy = c.busy;
            endcase
         end
         // soft reset drops motion but keeps the profile
         if (soft_rst)
         begin
            c.busy = 1'b0;                                 // see RQ3
            c.rem  = 32'h0000_0000;
            c.pos  = '0;
            c.cur  = '0;
            hw_clr[i] = 1'b1;
            hw_set[i] = 1'b0;
         end
         d.ch[i] = c;
      end
      // register writes
      if (bus_i.wr)
      begin
         case (bus_i.addr)
            REG_ARG:  d.arg  = bus_i.wdata;
            REG_CFG:  d.cfgw = bus_i.wdata;
            REG_MASK: d.mask = bus_i.wdata[NCH-1:0];
            default:  d.arg  = d.arg;
         endcase
      end
      // completion flags: write one to clear, a hardware set wins
      d.stat = q.stat & ~hw_clr;
      if (bus_i.wr && bus_i.addr == REG_STAT)
         d.stat = d.stat & ~bus_i.wdata[NCH-1:0];
      d.stat = d.stat | hw_set;
      d.irq  = |(d.stat & d.mask);
      // read data appears only in the cycle after the strobe
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            REG_ARG:  d.rdata = q.arg;
            REG_CFG:  d.rdata = q.cfgw;
            REG_STAT: d.rdata = {25'h0000000, q.ch[2].busy, q.ch[1].busy, q.ch[0].busy, 1'b0, q.stat};
            REG_MASK: d.rdata = {29'h00000000, q.mask};
            default:
            begin
               for (int i = 0; i < NCH; i++)
               begin
                  if (bus_i.addr == REG_POS0 + 8'(4 * i))
                     d.rdata = q.ch[i].pos;                // see RQ14
                  if (bus_i.addr == REG_REM0 + 8'(4 * i))
                     d.rdata = q.ch[i].rem;
                  if (bus_i.addr == REG_PROF0 + 8'(4 * i))
                     d.rdata = {q.ch[i].accs, q.ch[i].cfg_ok, q.ch[i].half, q.ch[i].pps};
               end
            end
         endcase
      end
   end

   // state register; profile cleared only at power-up
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= d;
   end

   // outputs come straight from state flops
   assign rdata_o = q.rdata;
   assign irq_o   = q.irq;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst || soft_rst);

   generate
      for (genvar g = 0; g < NCH; g++)
      begin : g_ch
         assign step_o[g] = q.ch[g].step;
         assign dir_o[g]  = q.ch[g].dir;
         assign half_o[g] = q.ch[g].half;

         // accepted relative or absolute move, whatever its count
         sequence start_s;
            cmd_hit(bus_i, g) && !q.ch[g].busy && q.ch[g].cfg_ok
               && (bus_i.wdata[CMD_OP_LSB +: 3] == OP_REL || bus_i.wdata[CMD_OP_LSB +: 3] == OP_ABS);
         endsequence
         sequence running_s;
            q.ch[g].busy && !q.stat[g];
         endsequence

         // a home command may land in the pulse cycle and rightly zero the position
         pos_per_pulse_a : assert property ($rose(q.ch[g].step)  // see RQ18
            && !$past(cmd_hit(bus_i, g) && bus_i.wdata[CMD_OP_LSB +: 3] == OP_HOME)
            |-> q.ch[g].pos == $past(q.ch[g].pos) + (q.ch[g].dir ? -1 : 1))
            else $error("position did not follow a pulse");
         rate_ceiling_a : assert property (q.ch[g].busy |-> q.ch[g].cur <= q.ch[g].pps  // see RQ4
            && q.ch[g].pps <= PPS_MAX)
            else $error("rate above configured top");
         move_clears_flag_a : assert property (start_s ##1 q.ch[g].busy |-> running_s)  // see RQ9
            else $error("flag not cleared on move start");
         ramp_start_a : assert property ($rose(q.ch[g].busy) && q.ch[g].accs != 16'h0000  // see RQ17
            |-> q.ch[g].cur == floor_rate(q.ch[g].pps))
            else $error("ramp did not start at floor rate");
         done_sets_flag_a : assert property ($fell(q.ch[g].busy) && $past(q.ch[g].rem) == 32'h1  // see RQ10
            |-> q.stat[g] && q.ch[g].rem == 32'h0)
            else $error("completion flag missing");
         busy_ignores_a : assert property (q.ch[g].busy && cmd_hit(bus_i, g)  // see RQ15
            && bus_i.wdata[CMD_OP_LSB +: 3] == OP_REL |=> $stable(q.ch[g].dir))
            else $error("move accepted while busy");
         // soft reset is the event watched here, so only power-up reset disables it
         profile_kept_a : assert property (disable iff (sys_rst) soft_rst  // see RQ3
            |=> $stable(q.ch[g].pps) && $stable(q.ch[g].accs))
            else $error("profile lost on soft reset");
         pulse_count_a : assert property ($rose(q.ch[g].step)  // see RQ7
            |-> q.ch[g].rem == $past(q.ch[g].rem) - 32'h1 || !q.ch[g].busy)
            else $error("pulse not counted");
         dir_steady_a : assert property (q.ch[g].busy && $past(q.ch[g].busy)  // see RQ16
            |-> $stable(q.ch[g].dir))
            else $error("direction changed mid move");
      end
   endgenerate

   irq_level_a : assert property (##1 irq_o == |(q.stat & q.mask))
      else $error("interrupt does not match flags");

endmodule : spdc_top
`default_nettype wire

// File: tb/spdc_drv_model.sv
// behavioural stepper driver that counts steps and checks the step rate
`timescale 1ns/1ps
`default_nettype none
module spdc_drv_model
   import spdc_pkg::*;
(
   input  wire logic                 clk_sys,  // system clock
   input  wire logic [NCH-1:0]       step_i,   // step pulses
   input  wire logic [NCH-1:0]       dir_i,    // direction levels
   output var  logic [NCH-1:0][31:0] pos_o,    // counted position
   output var  int                   viol_o    // too-fast steps seen
);
   logic [NCH-1:0] step_q;
   int             gap [NCH];

   // start with a long gap so the first step never counts as too fast
   initial
   begin
      viol_o = 0;
      pos_o  = '0;
      step_q = '0;
      foreach (gap[i])
         gap[i] = CLK_HZ;
   end

   // a real driver acts on the rising edge only and reads dir there
   always @(posedge clk_sys)
   begin
      for (int i = 0; i < NCH; i++)
      begin
         gap[i] = gap[i] + 1;
         if (step_i[i] && !step_q[i])
         begin
            if (gap[i] < CLK_HZ / int'(PPS_MAX))
               viol_o = viol_o + 1;
            gap[i] = 0;
            pos_o[i] = dir_i[i] ? pos_o[i] - 32'h1 : pos_o[i] + 32'h1;
         end
      end
      step_q = step_i;
   end
endmodule : spdc_drv_model
`default_nettype wire

// File: tb/stepper_pulse_direction_controller_bench.sv
// self-checking bench: register tasks, moves, abort, interrupt, soft reset
`timescale 1ns/1ps
`default_nettype none
module stepper_pulse_direction_controller_bench
   import spdc_pkg::*;
();
   logic                 clk_sys;
   logic                 sys_rst;
   logic                 soft_rst;
   spdc_bus_type         bus;
   logic [31:0]          rdata;
   logic [NCH-1:0]       step;
   logic [NCH-1:0]       dir;
   logic [NCH-1:0]       half;
   logic                 irq;
   logic [NCH-1:0][31:0] dpos;
   int                   viol;
   int                   miscompares;
   int                   n_tests;

   spdc_top u_spdc_top (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .soft_rst (soft_rst),
      .bus_i    (bus),
      .rdata_o  (rdata),
      .step_o   (step),
      .dir_o    (dir),
      .half_o   (half),
      .irq_o    (irq)
   );

   spdc_drv_model u_spdc_drv_model (
      .clk_sys (clk_sys),
      .step_i  (step),
      .dir_i   (dir),
      .pos_o   (dpos),
      .viol_o  (viol)
   );

   // 50 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever
         #10 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one-cycle strobes; a new access waits for the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask : rchk

   task automatic move(input logic [2:0] op, input logic [1:0] ch, input logic [31:0] arg);
      wr(REG_ARG, arg);
      wr(REG_CMD, {27'h0, op, ch});
   endtask : move

   // polls channel 1 busy with a bounded count
   task automatic wait_idle();
      for (int i = 0; i < 20000; i++)
      begin
         @(posedge clk_sys);
         bus.addr <= REG_STAT;
         bus.rd   <= 1'b1;
         @(posedge clk_sys);
         bus.rd <= 1'b0;
         #1;
         if (rdata[4] === 1'b0)
            return;
      end
      miscompares++;
      $display("FAIL wait_idle expected idle seen busy");
      end_sim();
   endtask : wait_idle

   initial
   begin
      int n;
      miscompares = 0;
      n_tests     = 0;
      sys_rst     = 1'b1;
      soft_rst    = 1'b0;
      bus         = '0;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // moves before a profile, and channel zero, are dropped
      move(OP_REL, 2'h1, 32'h3);
      move(OP_REL, 2'h0, 32'h3);
      rchk(REG_STAT, 32'h0, "stat refused");
      rchk(REG_PROF0, 32'h0, "prof unloaded");
      $display("test refusal done");
      // over-range and zero rates are clamped on load
      wr(REG_CFG, 32'h0000_3FFF);
      move(OP_CFG, 2'h1, 32'h0);
      rchk(REG_PROF0, 32'h0000_A710, "prof ch1");
      wr(REG_CFG, 32'h0032_0064);
      move(OP_CFG, 2'h2, 32'h0);
      rchk(REG_PROF0 + 8'h04, 32'h0032_8064, "prof ch2");
      wr(REG_CFG, 32'h0000_4000);
      move(OP_CFG, 2'h3, 32'h0);
      rchk(REG_PROF0 + 8'h08, 32'h0000_C001, "prof ch3");
      chk("half", 32'h4, {29'h0, half});
      $display("test profile done");
      // second move while busy must be ignored
      move(OP_REL, 2'h1, 32'h3);
      move(OP_REL, 2'h1, 32'h64);
      rchk(REG_STAT, 32'h10, "stat busy");
      wait_idle();
      rchk(REG_POS0, 32'h3, "pos fwd");
      chk("steps fwd", 32'h3, dpos[0]);
      move(OP_REL, 2'h1, 32'hFFFF_FFFE);
      rchk(REG_STAT, 32'h10, "flag cleared");
      chk("dir neg", 32'h1, {31'h0, dir[0]});
      wait_idle();
      rchk(REG_STAT, 32'h1, "flag set");
      chk("steps back", 32'h1, dpos[0]);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(REG_MASK, 32'h1);
      @(posedge clk_sys);
      #1 chk("irq raised", 32'h1, {31'h0, irq});
      wr(REG_STAT, 32'h1);
      @(posedge clk_sys);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test relative done");
      // target -1 from +1: two steps backward
      move(OP_ABS, 2'h1, 32'hFFFF_FFFF);
      // let the command edge settle before looking at the direction flop
      #1 chk("dir abs", 32'h1, {31'h0, dir[0]});
      wait_idle();
      rchk(REG_STAT, 32'h1, "abs flag");
      rchk(REG_POS0, 32'hFFFF_FFFF, "pos abs");
      chk("steps abs", 32'hFFFF_FFFF, dpos[0]);
      $display("test absolute done");
      // abort after the first pulse; position read mid-move
      move(OP_REL, 2'h1, 32'hA);
      for (n = 0; n < 6000 && dpos[0] === 32'hFFFF_FFFF; n++)
         @(posedge clk_sys);
      if (n == 6000)
      begin
         miscompares++;
         end_sim();
      end
      rchk(REG_POS0, 32'h0, "pos moving");
      rchk(REG_REM0, 32'h9, "rem moving");
      move(OP_STOP, 2'h1, 32'h0);
      repeat (6000) @(posedge clk_sys);
      rchk(REG_STAT, 32'h0, "stat aborted");
      rchk(REG_POS0, 32'h0, "pos aborted");
      chk("steps aborted", 32'h0, dpos[0]);
      move(OP_HOME, 2'h1, 32'h0);
      $display("test abort done");
      // soft reset keeps the profile: a move runs without reloading
      @(posedge clk_sys);
      soft_rst <= 1'b1;
      @(posedge clk_sys);
      soft_rst <= 1'b0;
      rchk(REG_PROF0, 32'h0000_A710, "prof kept");
      move(OP_REL, 2'h1, 32'h1);
      wait_idle();
      rchk(REG_POS0, 32'h1, "pos after soft");
      chk("steps after soft", 32'h1, dpos[0]);
      chk("rate", 32'h0, viol);
      $display("test soft reset done");
      end_sim();
   end
endmodule : stepper_pulse_direction_controller_bench
`default_nettype wire
